// ---- verilog/ior_pkg.sv ----
// Constants and carrier types for the inertial output register readout.
package ior_pkg;
	// Serial frame layout.
	localparam int FRAME_BITS = 16;
	localparam int ADDR_BITS = 6;
	localparam int ADDR_MSB_POS = 13;
	localparam int SYNC_STAGES = 3;
	// Output word layout.
	localparam int FRESH_POS = 15;
	localparam int FAULT_POS = 14;
	localparam int SAMPLE_W = 14;
	localparam int NARROW_W = 12;
	// Channel order in the sample bank.
	localparam int NUM_CHAN = 11;
	localparam logic [3:0] CH_SUPPLY = 4'h0;
	localparam logic [3:0] CH_RATE_X = 4'h1;
	localparam logic [3:0] CH_RATE_Y = 4'h2;
	localparam logic [3:0] CH_RATE_Z = 4'h3;
	localparam logic [3:0] CH_ACCEL_X = 4'h4;
	localparam logic [3:0] CH_ACCEL_Y = 4'h5;
	localparam logic [3:0] CH_ACCEL_Z = 4'h6;
	localparam logic [3:0] CH_THERM_X = 4'h7;
	localparam logic [3:0] CH_THERM_Y = 4'h8;
	localparam logic [3:0] CH_THERM_Z = 4'h9;
	localparam logic [3:0] CH_AUX = 4'ha;
	localparam logic [3:0] CH_NONE = 4'hf;
	// Lower byte addresses of the output words.
	localparam logic [5:0] ADDR_SUPPLY = 6'h02;
	localparam logic [5:0] ADDR_RATE_X = 6'h04;
	localparam logic [5:0] ADDR_RATE_Y = 6'h06;
	localparam logic [5:0] ADDR_RATE_Z = 6'h08;
	localparam logic [5:0] ADDR_ACCEL_X = 6'h0a;
	localparam logic [5:0] ADDR_ACCEL_Y = 6'h0c;
	localparam logic [5:0] ADDR_ACCEL_Z = 6'h0e;
	localparam logic [5:0] ADDR_THERM_X = 6'h10;
	localparam logic [5:0] ADDR_THERM_Y = 6'h12;
	localparam logic [5:0] ADDR_THERM_Z = 6'h14;
	localparam logic [5:0] ADDR_AUX = 6'h16;
	localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
	// Scale figures per LSB, in micro units, kept for reference by users.
	localparam int RATE_300_UDPS = 73260;
	localparam int RATE_150_UDPS = 36630;
	localparam int RATE_75_UDPS = 18315;
	localparam int ACCEL_UMG = 467200;
	localparam int THERM_UDEGC = 145300;
	localparam int AUX_UMV = 610500;
	localparam int SUPPLY_UMV = 1831500;
	typedef enum logic [1:0] {
		IOR_RANGE_300,
		IOR_RANGE_150,
		IOR_RANGE_75
	} ior_range_t;
	// One converter update on a channel.
	typedef struct packed {
		logic valid;
		logic [3:0] chan;
		logic [13:0] value;
	} ior_sample_t;
	// Serial pins as the device drives them.
	typedef struct packed {
		logic dout;
		logic dout_oe;
	} ior_spi_out_t;
endpackage : ior_pkg

// ---- verilog/ior_sync.sv ----
// Three-stage synchroniser with agreement check for one pin.
`timescale 1ns/1ps
module ior_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock, reset, enable.
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Pin and filtered level.
	input wire logic pin_i,
	output logic level_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} ior_sync_t;
	ior_sync_t st_q;
	ior_sync_t st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.s1 = pin_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// The first stage is read only by the second.
		if (st_q.s2 == st_q.s3)
		begin
			st_d.lvl = st_q.s3;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			st_q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
		end
		else if (ce_i)
		begin
			st_q <= st_d;
		end
	end

	assign level_o = st_q.lvl;
endmodule : ior_sync

// ---- verilog/ior_readout.sv ----
// Output sample registers and their serial read port.
//
// Behaviour
// - Samples refresh from converter updates whether or not the host reads.
// - Word bit 15 is fresh flag, bit 14 fault flag, 13..0 sample.
// - Loading a new sample sets that word's fresh flag.
// - A read of the word clears its fresh flag until next refresh.
// - Fault flag follows the live fault input in every mapped word; an unmapped address reads 0x0000 with no fault flag.
// - Samples are 12 or 14 bits; host ignores bits 13..12 on 12-bit.
// - Rate words are 14-bit two's complement at 0x04, 0x06, 0x08.
// - Rate LSB weight follows the selected range of 300, 150 or 75.
// - Acceleration words are 14-bit two's complement at 0x0a..0x0e.
// - Temperature words are 12-bit two's complement at 0x10..0x14.
// - Aux word 0x16 and supply word 0x02 are 12-bit binary.
// - Rate and acceleration codes span 14 data bits, minus one 0x3fff; thermal minus one is 0x0fff.
// - Next frame shifts out all 16 bits; both byte addresses alike.
// - Chip select high: output released, clock and data ignored.
`timescale 1ns/1ps
module ior_readout (
	// Clock, reset, enable.
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Converter updates and status.
	input wire ior_pkg::ior_sample_t sample_i,
	input wire logic fault_i,
	input wire ior_pkg::ior_range_t range_i,
	// Serial port pins.
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_din_i,
	output ior_pkg::ior_spi_out_t spi_o,
	// Status.
	output ior_pkg::ior_range_t range_o
);
	localparam int CW = $clog2(ior_pkg::FRAME_BITS + 1);

	typedef struct packed {
		logic [ior_pkg::NUM_CHAN-1:0][13:0] value;
		logic [ior_pkg::NUM_CHAN-1:0] fresh;
		logic sclk_prev;
		logic in_frame;
		logic [CW-1:0] bit_cnt;
		logic [15:0] rx_shift;
		logic [15:0] tx_shift;
		logic [3:0] pend_chan;
		logic [3:0] tx_chan;
		logic tx_renewed;
		logic dout;
		logic dout_oe;
		ior_pkg::ior_range_t range;
	} ior_state_t;

	ior_state_t st_q;
	ior_state_t st_d;
	logic cs_n_s;
	logic sclk_s;
	logic din_s;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	ior_sync #(.RESET_VAL(1'b1)) u_sync_cs (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.pin_i(spi_cs_n_i),
		.level_o(cs_n_s)
	);
	ior_sync #(.RESET_VAL(1'b1)) u_sync_sclk (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.pin_i(spi_sclk_i),
		.level_o(sclk_s)
	);
	ior_sync #(.RESET_VAL(1'b0)) u_sync_din (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.pin_i(spi_din_i),
		.level_o(din_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Both byte addresses of a word map to the same channel.
	function automatic logic [3:0] decode_chan(input logic [5:0] addr);
		logic [5:0] a;
		a = {addr[5:1], 1'b0};
		unique case (a)
			ior_pkg::ADDR_SUPPLY: decode_chan = ior_pkg::CH_SUPPLY;
			ior_pkg::ADDR_RATE_X: decode_chan = ior_pkg::CH_RATE_X;
			ior_pkg::ADDR_RATE_Y: decode_chan = ior_pkg::CH_RATE_Y;
			ior_pkg::ADDR_RATE_Z: decode_chan = ior_pkg::CH_RATE_Z;
			ior_pkg::ADDR_ACCEL_X: decode_chan = ior_pkg::CH_ACCEL_X;
			ior_pkg::ADDR_ACCEL_Y: decode_chan = ior_pkg::CH_ACCEL_Y;
			ior_pkg::ADDR_ACCEL_Z: decode_chan = ior_pkg::CH_ACCEL_Z;
			ior_pkg::ADDR_THERM_X: decode_chan = ior_pkg::CH_THERM_X;
			ior_pkg::ADDR_THERM_Y: decode_chan = ior_pkg::CH_THERM_Y;
			ior_pkg::ADDR_THERM_Z: decode_chan = ior_pkg::CH_THERM_Z;
			ior_pkg::ADDR_AUX: decode_chan = ior_pkg::CH_AUX;
			default: decode_chan = ior_pkg::CH_NONE;
		endcase
	endfunction : decode_chan

	// Twelve-bit channels: supply, the three thermal words and aux.
	function automatic logic is_narrow(input logic [3:0] ch);
		is_narrow = (ch == ior_pkg::CH_SUPPLY) || (ch == ior_pkg::CH_AUX)
			|| (ch == ior_pkg::CH_THERM_X) || (ch == ior_pkg::CH_THERM_Y)
			|| (ch == ior_pkg::CH_THERM_Z);
	endfunction : is_narrow

	// Twelve-bit codes, signed thermal and binary alike, are not sign-extended:
	// bits 13..12 are kept at zero.
	function automatic logic [13:0] shape(input logic [3:0] ch,
		input logic [13:0] v);
		logic [13:0] r;
		r = v;
		if (is_narrow(ch))
		begin
			r = {2'b00, v[11:0]};
		end
		shape = r;
	endfunction : shape

	////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb
	begin
		logic rise;
		logic fall;
		logic [15:0] word;
		rise = 1'b0;
		fall = 1'b0;
		word = ior_pkg::UNMAPPED_WORD;
		st_d = st_q;
		st_d.sclk_prev = sclk_s;
		st_d.range = range_i;

		// Converter updates land regardless of host activity.
		if (sample_i.valid && (sample_i.chan < 4'(ior_pkg::NUM_CHAN)))
		begin
			st_d.value[sample_i.chan] = shape(sample_i.chan,
				sample_i.value);
		end

		if (cs_n_s)
		begin
			// Pins are ignored and the output is released.
			st_d.in_frame = 1'b0;
			st_d.dout_oe = 1'b0;
			st_d.bit_cnt = '0;
		end
		else
		begin
			rise = sclk_s && !st_q.sclk_prev;
			fall = !sclk_s && st_q.sclk_prev;
			if (!st_q.in_frame)
			begin
				// Whole word latched at frame start.
				if (st_q.pend_chan != ior_pkg::CH_NONE)
				begin
					word = {st_q.fresh[st_q.pend_chan], fault_i,
						st_q.value[st_q.pend_chan]};
				end
				st_d.tx_shift = {word[14:0], 1'b0};
				st_d.dout = word[15];
				st_d.tx_chan = st_q.pend_chan;
				st_d.tx_renewed = 1'b0;
				st_d.in_frame = 1'b1;
				st_d.dout_oe = 1'b1;
				st_d.bit_cnt = '0;
			end
			else
			begin
				if (rise && (st_q.bit_cnt < CW'(ior_pkg::FRAME_BITS)))
				begin
					st_d.rx_shift = {st_q.rx_shift[14:0], din_s};
					st_d.bit_cnt = st_q.bit_cnt + CW'(1);
				end
				// The leading fall only opens the frame: bit 15 already
				// stands since the capture, so shifting there would lose it.
				if (fall && (st_q.bit_cnt != '0)
					&& (st_q.bit_cnt < CW'(ior_pkg::FRAME_BITS)))
				begin
					st_d.dout = st_q.tx_shift[15];
					st_d.tx_shift = {st_q.tx_shift[14:0], 1'b0};
				end
			end
		end

		// Frame ends when chip select rises after a full 16 clocks.
		if (cs_n_s && st_q.in_frame
			&& (st_q.bit_cnt == CW'(ior_pkg::FRAME_BITS)))
		begin
			// A refresh after the capture was never shown, so it stays new.
			if ((st_q.tx_chan != ior_pkg::CH_NONE) && !st_q.tx_renewed)
			begin
				st_d.fresh[st_q.tx_chan] = 1'b0;
			end
			// Two leading zeros mark a read request.
			if (st_q.rx_shift[15:14] == 2'b00)
			begin
				st_d.pend_chan = decode_chan(
					st_q.rx_shift[ior_pkg::ADDR_MSB_POS -: ior_pkg::ADDR_BITS]);
			end
			else
			begin
				st_d.pend_chan = ior_pkg::CH_NONE;
			end
		end

		// A refresh in the same cycle as the clear wins.
		if (sample_i.valid && (sample_i.chan < 4'(ior_pkg::NUM_CHAN)))
		begin
			st_d.fresh[sample_i.chan] = 1'b1;
			if (sample_i.chan == st_d.tx_chan)
			begin
				st_d.tx_renewed = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			st_q <= '0;
			st_q.sclk_prev <= 1'b1;
			st_q.pend_chan <= ior_pkg::CH_NONE;
			st_q.tx_chan <= ior_pkg::CH_NONE;
			st_q.range <= ior_pkg::IOR_RANGE_300;
		end
		else if (ce_i)
		begin
			st_q <= st_d;
		end
	end

	assign spi_o.dout = st_q.dout;
	assign spi_o.dout_oe = st_q.dout_oe;
	assign range_o = st_q.range;
endmodule : ior_readout

// ---- sim/ior_readout_monitor.sv ----
// Checker for the readout serial port and status outputs.
`timescale 1ns/1ps
module ior_readout_monitor (
	// Clock, reset, enable.
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Converter side.
	input wire ior_pkg::ior_sample_t sample_i,
	input wire logic fault_i,
	input wire ior_pkg::ior_range_t range_i,
	// Serial pins and status.
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_din_i,
	input wire ior_pkg::ior_spi_out_t spi_o,
	input wire ior_pkg::ior_range_t range_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);
	chk_idle_release: assert property (
		spi_cs_n_i [*6] |-> !spi_o.dout_oe) else $error("oe while idle");
	chk_drive_sel: assert property (
		!spi_cs_n_i [*6] |-> spi_o.dout_oe) else $error("oe missing");
	chk_oe_start: assert property (
		$rose(spi_o.dout_oe) |-> $past(spi_cs_n_i, 2) == 1'b0)
		else $error("oe rose early");
	chk_oe_end: assert property (
		$fell(spi_o.dout_oe) |-> $past(spi_cs_n_i, 2) == 1'b1)
		else $error("oe fell early");
	chk_oe_hold: assert property (
		spi_o.dout_oe && !spi_cs_n_i |=> spi_o.dout_oe)
		else $error("oe dropped");
	// Bits may only move after a falling clock, never in a long high phase.
	chk_bit_hold: assert property (
		spi_sclk_i [*6] ##0 (spi_o.dout_oe && $past(spi_o.dout_oe))
		|-> $stable(spi_o.dout)) else $error("dout moved");
	chk_range_copy: assert property (
		$stable(range_i) [*3] |-> range_o == range_i)
		else $error("range copy");
	chk_reset_quiet: assert property (disable iff (1'b0)
		srst_i |=> !spi_o.dout_oe) else $error("oe after reset");
endmodule : ior_readout_monitor
bind ior_readout ior_readout_monitor ior_readout_monitor_inst (.*);

// ---- sim/ior_host_model.sv ----
// Behavioural serial host that polls the readout in clock mode 3.
`timescale 1ns/1ps
module ior_host_model (
	// Clock.
	input wire logic clk_sys_i,
	// Serial pins.
	output logic cs_n_o,
	output logic sclk_o,
	output logic din_o,
	input wire ior_pkg::ior_spi_out_t spi_i
);
	// A released line floats, so an undriven bit never passes a compare.
	wire logic miso = spi_i.dout_oe ? spi_i.dout : 1'bz;
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b1;
		din_o = 1'b0;
	end
	// Bits are taken at the end of the high phase, well after the shift.
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		@(negedge clk_sys_i);
		cs_n_o = 1'b0;
		repeat (8) @(negedge clk_sys_i);
		for (int i = 15; i >= 0; i--)
		begin
			sclk_o = 1'b0;
			din_o = tx[i];
			repeat (4) @(negedge clk_sys_i);
			sclk_o = 1'b1;
			repeat (4) @(negedge clk_sys_i);
			rx[i] = miso;
		end
		cs_n_o = 1'b1;
		din_o = ~din_o;
		repeat (6) @(negedge clk_sys_i);
	endtask : xfer
endmodule : ior_host_model

// ---- sim/testbench.sv ----
// Self-checking bench for the output register readout.
`timescale 1ns/1ps
module testbench;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	ior_pkg::ior_sample_t smp = '0;
	logic fault = 1'b0;
	ior_pkg::ior_range_t rng = ior_pkg::IOR_RANGE_300;
	ior_pkg::ior_range_t rng_o;
	ior_pkg::ior_spi_out_t spi;
	logic cs_n;
	logic sclk;
	logic din;
	logic [15:0] w;
	logic [13:0] v;
	int num_errors = 0;
	int checks_done = 0;
	initial
	begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	ior_readout ior_readout_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.ce_i(1'b1), .sample_i(smp), .fault_i(fault), .range_i(rng),
		.spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_din_i(din),
		.spi_o(spi), .range_o(rng_o));
	ior_host_model ior_host_model_inst (.clk_sys_i(clk_sys_i),
		.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .spi_i(spi));
	task automatic summarize();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic check(input string what, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic load(input logic [3:0] ch, input logic [13:0] val);
		@(negedge clk_sys_i);
		smp = '{1'b1, ch, val};
		@(negedge clk_sys_i);
		smp.valid = 1'b0;
	endtask : load
	// The answer comes one frame after the request.
	task automatic rd(input logic [5:0] a, output logic [15:0] got);
		logic [15:0] junk;
		ior_host_model_inst.xfer({2'b00, a, 8'h00}, junk);
		ior_host_model_inst.xfer(16'h0000, got);
	endtask : rd
	initial
	begin
		repeat (3) @(negedge clk_sys_i);
		srst_i = 1'b0;
		repeat (6) @(negedge clk_sys_i);
		for (int c = 0; c < 11; c++)
			load(4'(c), 14'h3ea0 | 14'(c));
		for (int c = 0; c < 11; c++)
		begin
			v = 14'h3ea0 | 14'(c);
			if (c == 0 || c > 6)
				v[13:12] = 2'b00;
			rd(6'h02 + 6'(2 * c) + 6'(c % 2), w);
			check("word", w, {2'b10, v});
		end
		rd(ior_pkg::ADDR_RATE_X, w);
		check("reread", w, 16'h3ea1);
		load(ior_pkg::CH_RATE_X, 14'h0111);
		load(ior_pkg::CH_RATE_X, 14'h3fff);
		rd(ior_pkg::ADDR_RATE_X | 6'h01, w);
		check("minus one", w, 16'hbfff);
		fault = 1'b1;
		rd(ior_pkg::ADDR_ACCEL_X, w);
		check("fault", w, 16'h7ea4);
		fault = 1'b0;
		rd(6'h18, w);
		check("unmapped", w, 16'h0000);
		fork
			rd(ior_pkg::ADDR_ACCEL_Y, w);
			begin
				#20us;
				load(ior_pkg::CH_ACCEL_Y, 14'h0123);
			end
		join
		check("atomic", w, 16'h3ea5);
		rd(ior_pkg::ADDR_ACCEL_Y, w);
		check("refresh", w, 16'h8123);
		for (int r = 0; r < 3; r++)
		begin
			rng = ior_pkg::ior_range_t'(r);
			repeat (2) @(negedge clk_sys_i);
			check("range", 16'(rng_o), 16'(r));
		end
		summarize();
	end
	initial
	begin
		#2ms;
		num_errors++;
		summarize();
	end
endmodule : testbench
